// *** pwmcs_top.v ***
// Purpose: enable, start polarity and clock select slice of an eight channel pwm
// Assumes: counters outside report period start and duty match per channel on clk
// Notes:   outputs are registered; absent channels read zero and ignore writes
//
// Our own choice: the strobed register port.
`timescale 1ns/1ps
`include "pwmcs_defs.vh"

module pwmcs_top #(
  parameter [7:0] CHAN_PRESENT = `PWMCS_CHAN_ALL
) (
  input  wire                       clk,
  input  wire                       reset_n,
  input  wire [`PWMCS_ADDR_W-1:0]   reg_addr,
  input  wire [7:0]                 reg_wdata,
  input  wire                       reg_wr,
  input  wire                       reg_rd,
  output reg  [7:0]                 reg_rdata,
  input  wire [7:0]                 period_start,
  input  wire [7:0]                 duty_match,
  output reg  [7:0]                 pwm_out,
  output reg  [7:0]                 chan_tick,
  output reg  [7:0]                 chan_run,
  output reg                        prescale_run
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg  [7:0] channel_enable_reg;
  reg  [7:0] polarity_reg;
  reg  [7:0] clock_select_reg;
  reg  [7:0] ab_swap_reg;
  reg  [7:0] prescale_reg;
  reg  [3:0] join_reg;
  reg  [7:0] scale_a;
  reg  [7:0] scale_b;

  reg  [6:0] pre_cnt;
  reg  [7:0] sa_cnt;
  reg  [7:0] sb_cnt;
  reg  [7:0] next_rdata;

  wire [7:0] chan_mask;
  wire [3:0] join_mask;
  wire [7:0] join_high;
  wire [7:0] eff_enable;
  wire       tick_a;
  wire       tick_b;
  wire       scaled_first_clock;
  wire       scaled_second_clock;
  wire [7:0] group_b;
  wire [7:0] sel_tick;
  wire       any_enable;
  wire       wr_enable;
  wire       wr_polarity;
  wire       wr_clksel;
  wire       wr_abswap;
  wire       wr_prescale;
  wire       wr_control;
  wire       wr_scale_a;
  wire       wr_scale_b;

  assign chan_mask = CHAN_PRESENT;
  // a pair can only be joined when both of its channels exist
  assign join_mask = {chan_mask[7] & chan_mask[6], chan_mask[5] & chan_mask[4],
                      chan_mask[3] & chan_mask[2], chan_mask[1] & chan_mask[0]};

  // ----------------------------------------------------------------
  // write decode
  // ----------------------------------------------------------------
  assign wr_enable   = reg_wr & (reg_addr == `PWMCS_OFF_ENABLE);
  assign wr_polarity = reg_wr & (reg_addr == `PWMCS_OFF_POLARITY);
  assign wr_clksel   = reg_wr & (reg_addr == `PWMCS_OFF_CLKSEL);
  assign wr_abswap   = reg_wr & (reg_addr == `PWMCS_OFF_ABSWAP);
  assign wr_prescale = reg_wr & (reg_addr == `PWMCS_OFF_PRESCALE);
  assign wr_control  = reg_wr & (reg_addr == `PWMCS_OFF_CONTROL);
  assign wr_scale_a  = reg_wr & (reg_addr == `PWMCS_OFF_SCALE_A);
  assign wr_scale_b  = reg_wr & (reg_addr == `PWMCS_OFF_SCALE_B);

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (!reset_n) begin
      channel_enable_reg <= `PWMCS_RST_BYTE;
    end else if (wr_enable) begin
      channel_enable_reg <= reg_wdata & chan_mask;
    end
  end

  always @(posedge clk) begin
    if (!reset_n) begin
      polarity_reg <= `PWMCS_RST_BYTE;
    end else if (wr_polarity) begin
      polarity_reg <= reg_wdata & chan_mask;
    end
  end

  always @(posedge clk) begin
    if (!reset_n) begin
      clock_select_reg <= `PWMCS_RST_BYTE;
    end else if (wr_clksel) begin
      clock_select_reg <= reg_wdata & chan_mask;
    end
  end

  always @(posedge clk) begin
    if (!reset_n) begin
      ab_swap_reg <= `PWMCS_RST_BYTE;
    end else if (wr_abswap) begin
      ab_swap_reg <= reg_wdata & chan_mask;
    end
  end

  always @(posedge clk) begin
    if (!reset_n) begin
      prescale_reg <= `PWMCS_RST_BYTE;
    end else if (wr_prescale) begin
      prescale_reg <= reg_wdata & `PWMCS_PRE_MASK;
    end
  end

  always @(posedge clk) begin
    if (!reset_n) begin
      join_reg <= 4'h0;
    end else if (wr_control) begin
      join_reg <= reg_wdata[`PWMCS_JOIN_LSB +: 4] & join_mask;
    end
  end

  always @(posedge clk) begin
    if (!reset_n) begin
      scale_a <= `PWMCS_RST_SCALE;
    end else if (wr_scale_a) begin
      scale_a <= reg_wdata;
    end
  end

  always @(posedge clk) begin
    if (!reset_n) begin
      scale_b <= `PWMCS_RST_SCALE;
    end else if (wr_scale_b) begin
      scale_b <= reg_wdata;
    end
  end

  // ----------------------------------------------------------------
  // register reads, data one cycle after the strobe
  // ----------------------------------------------------------------
  always @* begin
    next_rdata = 8'h00;
    case (reg_addr)
      `PWMCS_OFF_ENABLE:   next_rdata = channel_enable_reg;
      `PWMCS_OFF_POLARITY: next_rdata = polarity_reg;
      `PWMCS_OFF_CLKSEL:   next_rdata = clock_select_reg;
      `PWMCS_OFF_ABSWAP:   next_rdata = ab_swap_reg;
      `PWMCS_OFF_PRESCALE: next_rdata = prescale_reg;
      `PWMCS_OFF_CONTROL:  next_rdata = {join_reg, 4'h0};
      `PWMCS_OFF_SCALE_A:  next_rdata = scale_a;
      `PWMCS_OFF_SCALE_B:  next_rdata = scale_b;
      default:             next_rdata = 8'h00;
    endcase
  end

  always @(posedge clk) begin
    if (!reset_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // effective enables
  // ----------------------------------------------------------------
  // high order channels are 6,4,2,0 of pairs 76,54,32,10
  assign join_high  = {1'b0, join_reg[3], 1'b0, join_reg[2], 1'b0, join_reg[1], 1'b0, join_reg[0]};
  assign eff_enable = channel_enable_reg & ~join_high;

  // ----------------------------------------------------------------
  // prescaler and clocks A, B
  // ----------------------------------------------------------------
  function div_tick;
    input [6:0] cnt;
    input [2:0] sel;
    reg   [6:0] mask;
    begin
      mask     = (7'h01 << sel) - 7'h01;
      div_tick = ((cnt & mask) == mask);
    end
  endfunction

  assign any_enable = |eff_enable;

  always @(posedge clk) begin
    if (!reset_n) begin
      prescale_run <= 1'b0;
    end else begin
      prescale_run <= any_enable;
    end
  end

  always @(posedge clk) begin
    if (!reset_n) begin
      pre_cnt <= 7'h00;
    end else if (any_enable) begin
      pre_cnt <= pre_cnt + 7'h01;
    end else begin
      pre_cnt <= 7'h00;
    end
  end

  assign tick_a = prescale_run & div_tick(pre_cnt, prescale_reg[`PWMCS_PRE_A_LSB +: 3]);
  assign tick_b = prescale_run & div_tick(pre_cnt, prescale_reg[`PWMCS_PRE_B_LSB +: 3]);

  // ----------------------------------------------------------------
  // scaled clocks, scale value zero divides by 256
  // ----------------------------------------------------------------
  assign scaled_first_clock  = tick_a & (sa_cnt == scale_a - 8'h01);
  assign scaled_second_clock = tick_b & (sb_cnt == scale_b - 8'h01);

  always @(posedge clk) begin
    if (!reset_n) begin
      sa_cnt <= 8'h00;
    end else if (wr_scale_a) begin
      sa_cnt <= 8'h00;
    end else if (scaled_first_clock) begin
      sa_cnt <= 8'h00;
    end else if (tick_a) begin
      sa_cnt <= sa_cnt + 8'h01;
    end
  end

  always @(posedge clk) begin
    if (!reset_n) begin
      sb_cnt <= 8'h00;
    end else if (wr_scale_b) begin
      sb_cnt <= 8'h00;
    end else if (scaled_second_clock) begin
      sb_cnt <= 8'h00;
    end else if (tick_b) begin
      sb_cnt <= sb_cnt + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // per channel clock select
  // ----------------------------------------------------------------
  // group b channels 2,3,6,7 prefer clock b
  assign group_b = `PWMCS_GROUP_B;

  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : sel_g
      reg pick;
      always @* begin
        pick = tick_a;
        case ({ab_swap_reg[g], clock_select_reg[g]})
          2'b00:   pick = group_b[g] ? tick_b : tick_a;
          2'b01:   pick = group_b[g] ? scaled_second_clock : scaled_first_clock;
          2'b10:   pick = group_b[g] ? tick_a : tick_b;
          2'b11:   pick = group_b[g] ? scaled_first_clock : scaled_second_clock;
          default: pick = tick_a;
        endcase
      end
      assign sel_tick[g] = pick;
    end
  endgenerate

  // ----------------------------------------------------------------
  // tick report
  // ----------------------------------------------------------------
  integer i;
  integer k;

  always @(posedge clk) begin
    if (!reset_n) begin
      chan_tick <= 8'h00;
    end else begin
      chan_tick <= sel_tick & eff_enable;
    end
  end

  // ----------------------------------------------------------------
  // channel start
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (!reset_n) begin
      chan_run <= 8'h00;
    end else begin
      for (i = 0; i < 8; i = i + 1) begin
        if (!eff_enable[i]) begin
          chan_run[i] <= 1'b0;
        end else if (sel_tick[i]) begin
          chan_run[i] <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // output level
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (!reset_n) begin
      pwm_out <= 8'h00;
    end else begin
      for (k = 0; k < 8; k = k + 1) begin
        if (!eff_enable[k]) begin
          pwm_out[k] <= 1'b0;
        end else if (!chan_run[k]) begin
          if (sel_tick[k]) begin
            pwm_out[k] <= polarity_reg[k];
          end
        end else if (duty_match[k]) begin
          pwm_out[k] <= ~polarity_reg[k];
        end else if (period_start[k]) begin
          pwm_out[k] <= polarity_reg[k];
        end
      end
    end
  end

endmodule

// *** pwmcs_defs.vh ***
// Purpose: offsets, field positions, reset values and fixed masks of the pwm channel slice
// Assumes: byte-wide registers at their own offsets on a plain register port
// Notes:   definitions only
`ifndef PWMCS_DEFS_VH
`define PWMCS_DEFS_VH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define PWMCS_ADDR_W        6
`define PWMCS_OFF_ENABLE    6'h00
`define PWMCS_OFF_POLARITY  6'h01
`define PWMCS_OFF_CLKSEL    6'h02
`define PWMCS_OFF_PRESCALE  6'h03
`define PWMCS_OFF_CONTROL   6'h05
`define PWMCS_OFF_ABSWAP    6'h06
`define PWMCS_OFF_SCALE_A   6'h08
`define PWMCS_OFF_SCALE_B   6'h09

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define PWMCS_PRE_A_LSB     0
`define PWMCS_PRE_B_LSB     4
`define PWMCS_PRE_MASK      8'h77
`define PWMCS_JOIN_LSB      4
`define PWMCS_JOIN_MASK     8'hf0

// ----------------------------------------------------------------
// reset values and fixed maps
// ----------------------------------------------------------------
`define PWMCS_RST_BYTE      8'h00
`define PWMCS_RST_SCALE     8'h00
`define PWMCS_CHAN_ALL      8'hff
`define PWMCS_GROUP_B       8'hcc
`define PWMCS_HIGH_ORDER    8'h55

`endif

// *** pwmcs_load.sv ***
// Purpose: load model on the channel output pins
// Assumes: one clock, synchronous active low reset
// Notes:   remembers every pin that was ever driven high
`timescale 1ns/1ps

module pwmcs_load (
  input  wire       clk,
  input  wire       reset_n,
  input  wire [7:0] pwm_out,
  output reg  [7:0] seen_high
);
  // ------------------------------------------------
  // sticky high detector
  // ------------------------------------------------
  always @(posedge clk) begin
    if (!reset_n)
      seen_high <= 8'h00;
    else
      seen_high <= seen_high | pwm_out;
  end
endmodule

// *** pwmcs_top_monitor.sv ***
// Purpose: port assertions of the pwm channel slice
// Assumes: single clock, synchronous active low reset
// Notes:   bound to pwmcs_top below
`timescale 1ns/1ps
`include "pwmcs_defs.vh"

module pwmcs_monitor (
  input wire                     clk,
  input wire                     reset_n,
  input wire [`PWMCS_ADDR_W-1:0] reg_addr,
  input wire                     reg_wr,
  input wire                     reg_rd,
  input wire [7:0]               reg_rdata,
  input wire [7:0]               period_start,
  input wire [7:0]               duty_match,
  input wire [7:0]               pwm_out,
  input wire [7:0]               chan_tick,
  input wire [7:0]               chan_run,
  input wire                     prescale_run
);
  // ------------------------------------------------
  // assertions
  // ------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside its slot");
  off_low_a: assert property ((pwm_out & ~chan_run) == 8'h00)
    else $error("idle channel output high");
  tick_run_a: assert property ((chan_tick & ~chan_run) == 8'h00)
    else $error("tick on a channel not running");
  start_sync_a: assert property ($rose(chan_run[0]) |-> chan_tick[0])
    else $error("channel started off its clock tick");
  run_pre_a: assert property (chan_run != 8'h00 |-> prescale_run)
    else $error("channel runs with prescaler stopped");
  pre_cause_a: assert property ($rose(prescale_run) |-> $past(reg_wr, 2) && $past(reg_addr, 2) == 6'h00)
    else $error("prescaler started without enable write");
  duty_flip_a: assert property (chan_run[1] && $past(chan_run[1], 2) && $past(period_start[1], 2)
    && !$past(duty_match[1], 2) && $past(duty_match[1]) |-> pwm_out[1] != $past(pwm_out[1]))
    else $error("duty match did not flip output");
  out_hold_a: assert property (chan_run[2] && $past(chan_run[2]) && !$past(duty_match[2] | period_start[2])
    |-> $stable(pwm_out[2])) else $error("output moved without event");
endmodule

bind pwmcs_top pwmcs_monitor pwmcs_monitor_i (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .period_start(period_start), .duty_match(duty_match),
  .pwm_out(pwm_out), .chan_tick(chan_tick), .chan_run(chan_run), .prescale_run(prescale_run));

// *** pwmcs_top_tb.sv ***
// Purpose: self-checking bench of the pwm channel slice
// Assumes: channels 6 and 7 absent in this build
// Notes:   register rows first, then decode, start and join cases
`timescale 1ns/1ps

module pwmcs_top_tb;
  logic       clk = 0, reset_n = 0, reg_wr = 0, reg_rd = 0;
  logic [5:0] reg_addr = 0;
  logic [7:0] reg_wdata = 0, period_start = 0, duty_match = 0, d;
  wire  [7:0] reg_rdata, pwm_out, chan_tick, chan_run, seen_high;
  wire        prescale_run;
  int         error_cnt = 0, total_checks = 0;
  logic [21:0] rows [8] = '{{6'h01, 8'ha5, 8'h25}, {6'h02, 8'h3c, 8'h3c}, {6'h06, 8'h0f, 8'h0f},
    {6'h05, 8'hff, 8'h70}, {6'h03, 8'hff, 8'h77}, {6'h08, 8'h12, 8'h12}, {6'h07, 8'h55, 8'h00}, {6'h00, 8'h00, 8'h00}};
  logic [23:0] modes [4] = '{{8'h00, 8'h00, 8'h33}, {8'hff, 8'h00, 8'h0c}, {8'h00, 8'hff, 8'h33}, {8'hff, 8'hff, 8'h0c}};

  pwmcs_top #(.CHAN_PRESENT(8'h3f)) pwmcs_top_i (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .period_start(period_start),
    .duty_match(duty_match), .pwm_out(pwm_out), .chan_tick(chan_tick), .chan_run(chan_run), .prescale_run(prescale_run));
  pwmcs_load pwmcs_load_i (.clk(clk), .reset_n(reset_n), .pwm_out(pwm_out), .seen_high(seen_high));

  always #10 clk = ~clk;

  // ------------------------------------------------
  // shared tasks
  // ------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_wr <= 1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 0;
  endtask
  task automatic rd(input logic [5:0] a);
    @(posedge clk);
    reg_rd <= 1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 0;
    #1 d = reg_rdata;
  endtask
  task automatic do_reset();
    @(posedge clk);
    reset_n <= 0;
    repeat (8) @(posedge clk);
    reset_n <= 1;
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial begin
    repeat (3000) @(posedge clk);
    error_cnt++;
    stop_test();
  end

  // ------------------------------------------------
  // scenarios
  // ------------------------------------------------
  initial begin
    repeat (8) @(posedge clk);
    reset_n <= 1;
    for (int i = 0; i < 3; i++) begin
      rd(i[5:0]);
      check(d, 8'h00);
    end
    foreach (rows[i]) begin
      wr(rows[i][21:16], rows[i][15:8]);
      rd(rows[i][21:16]);
      check(d, rows[i][7:0]);
    end
    foreach (modes[i]) begin
      do_reset();
      wr(6'h03, 8'h70);
      wr(6'h08, 8'h01);
      wr(6'h06, modes[i][23:16]);
      wr(6'h02, modes[i][15:8]);
      wr(6'h00, 8'hff);
      repeat (6) @(posedge clk);
      #1 check(chan_run, modes[i][7:0]);
      check(chan_run & 8'hcc, modes[i][7:0] & 8'hcc);
    end
    do_reset();
    wr(6'h01, 8'h0f);
    wr(6'h00, 8'hff);
    repeat (3) @(posedge clk);
    #1 check(chan_run, 8'h3f);
    check(pwm_out, 8'h0f);
    @(posedge clk);
    period_start <= 8'hff;
    @(posedge clk);
    period_start <= 8'h00;
    duty_match <= 8'hff;
    #1 check(pwm_out, 8'h0f);
    @(posedge clk);
    duty_match <= 8'h00;
    #1 check(pwm_out, 8'h30);
    wr(6'h01, 8'h0e);
    rd(6'h01);
    check(d, 8'h0e);
    wr(6'h00, 8'h00);
    repeat (2) @(posedge clk);
    #1 check(pwm_out | chan_run, 8'h00);
    do_reset();
    wr(6'h05, 8'hf0);
    wr(6'h01, 8'hff);
    wr(6'h00, 8'h55);
    repeat (4) @(posedge clk);
    #1 check(chan_run, 8'h00);
    check({7'h00, prescale_run}, 8'h00);
    wr(6'h00, 8'hff);
    repeat (4) @(posedge clk);
    #1 check(chan_run & pwm_out, 8'h2a);
    check(seen_high & 8'h55, 8'h00);
    check({7'h00, prescale_run}, 8'h01);
    rd(6'h00);
    check(d, 8'h3f);
    do_reset();
    wr(6'h03, 8'h01);
    wr(6'h08, 8'h03);
    wr(6'h02, 8'h01);
    wr(6'h00, 8'h01);
    repeat (5) @(posedge clk);
    #1 check(chan_run, 8'h00);
    @(posedge clk);
    #1 check(chan_run, 8'h01);
    check(chan_tick, 8'h01);
    wr(6'h02, 8'h00);
    rd(6'h02);
    check(d, 8'h00);
    check(chan_run, 8'h01);
    do_reset();
    #1 check(chan_run | pwm_out, 8'h00);
    stop_test();
  end
endmodule
